//--- verilog/alu_ops_consts.vh
// Constants and opcode codes for the arithmetic and control operation block
// What this block does
// RQ1 - Register add: reg plus work register, carry form adds C; Z, DC, C; one cycle
// RQ2 - Register subtract: reg plus inverted work register, borrow form adds C; one cycle
// RQ3 - Immediate add/subtract combine 8-bit immediate with work register, result to it
// RQ4 - Destination bit 0 writes work register, 1 writes back the addressed register
// RQ5 - C set on add carry or no subtract borrow, cleared otherwise
// RQ6 - Decimal adjust fixes work register to packed BCD in one cycle, touches C only
// RQ7 - Timeout and power-down flags are 1 after power-up and after watchdog kick
// RQ8 - Halt entry enters Halt mode, clears power-down flag, sets timeout flag
// RQ9 - Watchdog timeout clears the active-low timeout flag
// RQ10 - Interrupt return pops return address, enables interrupts, two cycles
// RQ11 - Indirect call pushes return address and jumps to work-register target
// RQ12 - Indirect jump goes to work-register target in two cycles
// RQ13 - Long jump and call use immediate address; call pushes; two cycles each
// RQ14 - Nonvolatile read loads data register from location at address register
// RQ15 - Nonvolatile write programs location at address register with data register
// RQ16 - Nonvolatile write only accepted after unlock with matching key code
// RQ17 - Register operands use a 6-bit address, 0x00 to 0x3F
// RQ18 - Bit set, clear and test pick one of eight bits by 3-bit field
// RQ19 - Digit carry is carry out of bit 3, complemented operand for subtracts
// RQ20 - Zero flag set when the written 8-bit result is zero
`ifndef ALU_OPS_CONSTS_VH
`define ALU_OPS_CONSTS_VH

`define OP_W 5
`define OP_ADD_R 5'h00
`define OP_ADC_R 5'h01
`define OP_SUB_R 5'h02
`define OP_SBC_R 5'h03
`define OP_ADD_I 5'h04
`define OP_ADC_I 5'h05
`define OP_SUB_I 5'h06
`define OP_SBC_I 5'h07
`define OP_BCD 5'h08
`define OP_KICK 5'h09
`define OP_HALT 5'h0A
`define OP_IRET 5'h0B
`define OP_ICALL 5'h0C
`define OP_IJMP 5'h0D
`define OP_LONG_CALL 5'h0E
`define OP_LJMP 5'h0F
`define OP_NV_RD 5'h10
`define OP_NV_WR 5'h11
`define OP_UNLOCK 5'h12
`define OP_BSET 5'h13
`define OP_BCLR 5'h14
`define OP_BTEST 5'h15
`define OP_NVA_LD 5'h16
`define OP_NVD_LD 5'h17
`define OP_NVD_RD 5'h18

`define RADDR_W 6
`define PC_W 11
`define NVM_KEY_RST 8'hA5
`define WREG_RST 8'h00
`define FLAGS_RST 1'b0
`define CYC_TWO 1

`endif

//--- verilog/add_unit.v
// Combinational adder with zero, digit carry and carry, plus decimal adjust
`timescale 1ns/1ps
module add_unit (
  a,
  b,
  cin,
  c_in_flag,
  dc_in_flag,
  sum,
  carry,
  digit_carry,
  zero,
  bcd_val,
  bcd_carry
);
  input wire [7:0] a;
  input wire [7:0] b;
  input wire cin;
  input wire c_in_flag;
  input wire dc_in_flag;
  output wire [7:0] sum;
  output wire carry;
  output wire digit_carry;
  output wire zero;
  output wire [7:0] bcd_val;
  output wire bcd_carry;

  wire [4:0] low_sum;
  wire [8:0] full_sum;
  wire lo_fix;
  wire hi_fix;
  wire [7:0] fix_val;
  wire [8:0] bcd_sum;

  // Nibble carry from bit 3, full carry from bit 7
  assign low_sum = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin}; // [RQ19]
  assign full_sum = {1'b0, a} + {1'b0, b} + {8'h00, cin}; // [RQ1] [RQ2]
  assign sum = full_sum[7:0];
  assign carry = full_sum[8]; // [RQ5]
  assign digit_carry = low_sum[4]; // [RQ19]
  assign zero = (full_sum[7:0] == 8'h00); // [RQ20]

  // Decimal correction on b (the work register)
  assign lo_fix = dc_in_flag | (b[3:0] > 4'h9); // [RQ6]
  assign hi_fix = c_in_flag | (b[7:4] > 4'h9) | ((b[7:4] == 4'h9) & (b[3:0] > 4'h9));
  assign fix_val = {(hi_fix ? 4'h6 : 4'h0), (lo_fix ? 4'h6 : 4'h0)};
  assign bcd_sum = {1'b0, b} + {1'b0, fix_val};
  assign bcd_val = bcd_sum[7:0]; // [RQ6]
  assign bcd_carry = hi_fix | bcd_sum[8]; // [RQ6]
endmodule // add_unit

//--- verilog/wdt_flags.v
// Timeout, power-down and Halt mode status flags
`timescale 1ns/1ps
module wdt_flags (
  mclk,
  resetn,
  kick,
  halt_enter,
  wake,
  wdt_timeout,
  watchdog_expired_n,
  powerdown_flag_n,
  halt_mode
);
  input wire mclk;
  input wire resetn;
  input wire kick;
  input wire halt_enter;
  input wire wake;
  input wire wdt_timeout;
  output reg watchdog_expired_n;
  output reg powerdown_flag_n;
  output reg halt_mode;

  // Reset is power-up: both flags high; timeout outranks a same-cycle kick
  always @(posedge mclk) begin
    if (!resetn) begin
      watchdog_expired_n <= 1'b1; // [RQ7]
      powerdown_flag_n <= 1'b1; // [RQ7]
      halt_mode <= 1'b0;
    end else begin
      if (wdt_timeout) begin
        watchdog_expired_n <= 1'b0; // [RQ9]
      end else if (kick | halt_enter) begin
        watchdog_expired_n <= 1'b1; // [RQ7] [RQ8]
      end
      if (halt_enter) begin
        powerdown_flag_n <= 1'b0; // [RQ8]
      end else if (kick) begin
        powerdown_flag_n <= 1'b1; // [RQ7]
      end
      if (halt_enter) begin
        halt_mode <= 1'b1; // [RQ8]
      end else if (wake | wdt_timeout) begin
        halt_mode <= 1'b0;
      end
    end
  end
endmodule // wdt_flags

//--- verilog/mcu_arith_and_control_ops.v
// Executes arithmetic, flow, watchdog and nonvolatile operations of the core
`timescale 1ns/1ps
`include "alu_ops_consts.vh"
module mcu_arith_and_control_ops #(
  parameter PC_W = `PC_W,
  parameter [7:0] NVM_KEY = `NVM_KEY_RST
) (
  input wire mclk,
  input wire resetn,
  input wire instr_valid,
  input wire [`OP_W-1:0] opcode,
  input wire [`RADDR_W-1:0] reg_addr,
  input wire dest_sel,
  input wire [2:0] bit_sel,
  input wire [7:0] imm,
  input wire [PC_W-1:0] addr_field,
  input wire [7:0] reg_rdata,
  input wire [PC_W-1:0] pc_next,
  input wire [PC_W-9:0] pc_high_buf,
  input wire [PC_W-1:0] pop_addr,
  input wire wdt_timeout,
  input wire wake,
  input wire nvm_rd_valid,
  input wire [7:0] nvm_rdata,
  output reg [7:0] work_register,
  output reg zero_flag,
  output reg digit_carry,
  output reg carry_flag,
  output wire watchdog_expired_n,
  output wire powerdown_flag_n,
  output wire halt_mode,
  output reg wdt_restart,
  output reg reg_we,
  output reg [`RADDR_W-1:0] reg_waddr,
  output reg [7:0] reg_wdata,
  output reg bit_test,
  output reg pc_load,
  output reg [PC_W-1:0] pc_target,
  output reg stack_push,
  output reg [PC_W-1:0] push_addr,
  output reg stack_pop,
  output reg int_enable,
  output reg busy,
  output reg [7:0] nvm_addr_reg,
  output reg [7:0] nvm_data_reg,
  output reg nvm_rd_req,
  output reg nvm_wr_req,
  output reg nvm_unlocked,
  output reg nvm_wr_refused
);

  // Sequencer states, one-hot
  localparam [1:0] ST_RUN = 2'b01;
  localparam [1:0] ST_SECOND = 2'b10;

  reg [1:0] state_q;
  reg [1:0] state_d;
  reg [7:0] opa;
  reg [7:0] opb;
  reg cin;
  reg arith_op;
  reg imm_form;
  wire take;
  wire [7:0] sum;
  wire add_c;
  wire add_dc;
  wire add_z;
  wire [7:0] bcd_val;
  wire bcd_c;
  wire [PC_W-1:0] wreg_target;
  wire kick;
  wire halt_enter;

  // New instruction taken only while not in a second cycle or Halt
  assign take = instr_valid & state_q[0] & ~halt_mode;
  assign kick = take & (opcode == `OP_KICK);
  assign halt_enter = take & (opcode == `OP_HALT);
  assign wreg_target = {pc_high_buf, work_register}; // [RQ11] [RQ12]

  // Operand selection for the eight add/subtract forms
  always @* begin
    arith_op = 1'b0;
    imm_form = 1'b0;
    opa = reg_rdata; // [RQ17]
    opb = work_register;
    cin = 1'b0;
    case (opcode)
      `OP_ADD_R, `OP_ADC_R, `OP_SUB_R, `OP_SBC_R: begin
        arith_op = 1'b1;
      end
      `OP_ADD_I, `OP_ADC_I, `OP_SUB_I, `OP_SBC_I: begin
        arith_op = 1'b1;
        imm_form = 1'b1;
        opa = imm; // [RQ3]
      end
      default: begin
        arith_op = 1'b0;
      end
    endcase
    if (opcode[1]) begin
      opb = ~work_register; // [RQ2] [RQ3]
    end
    if (opcode[0]) begin
      cin = carry_flag; // [RQ1] [RQ2] [RQ3]
    end
  end

  add_unit u_add (
    .a(opa),
    .b(opb),
    .cin(cin),
    .c_in_flag(carry_flag),
    .dc_in_flag(digit_carry),
    .sum(sum),
    .carry(add_c),
    .digit_carry(add_dc),
    .zero(add_z),
    .bcd_val(bcd_val),
    .bcd_carry(bcd_c)
  );

  wdt_flags u_flags (
    .mclk(mclk),
    .resetn(resetn),
    .kick(kick),
    .halt_enter(halt_enter),
    .wake(wake),
    .wdt_timeout(wdt_timeout),
    .watchdog_expired_n(watchdog_expired_n),
    .powerdown_flag_n(powerdown_flag_n),
    .halt_mode(halt_mode)
  );

  // Two-cycle flow operations hold off the next instruction one cycle
  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (take && (opcode == `OP_IRET || opcode == `OP_ICALL || opcode == `OP_IJMP ||
            opcode == `OP_LONG_CALL || opcode == `OP_LJMP)) begin
          state_d = ST_SECOND; // [RQ10] [RQ12] [RQ13]
        end
      end
      ST_SECOND: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  // Sequencer and busy flag
  always @(posedge mclk) begin
    if (!resetn) begin
      state_q <= ST_RUN;
      busy <= 1'b0;
    end else begin
      state_q <= state_d;
      busy <= state_d[1];
    end
  end

  // Work register, arithmetic flags and register write-back
  always @(posedge mclk) begin
    if (!resetn) begin
      work_register <= `WREG_RST;
      zero_flag <= `FLAGS_RST;
      digit_carry <= `FLAGS_RST;
      carry_flag <= `FLAGS_RST;
      reg_we <= 1'b0;
      reg_waddr <= {`RADDR_W{1'b0}};
      reg_wdata <= 8'h00;
      bit_test <= 1'b0;
    end else begin
      reg_we <= 1'b0;
      if (take && arith_op) begin
        zero_flag <= add_z; // [RQ20]
        digit_carry <= add_dc; // [RQ19]
        carry_flag <= add_c; // [RQ5]
        if (imm_form || !dest_sel) begin
          work_register <= sum; // [RQ3] [RQ4]
        end else begin
          reg_we <= 1'b1; // [RQ4]
          reg_waddr <= reg_addr; // [RQ17]
          reg_wdata <= sum;
        end
      end else if (take) begin
        case (opcode)
          `OP_BCD: begin
            work_register <= bcd_val; // [RQ6]
            carry_flag <= bcd_c; // [RQ6]
          end
          `OP_BSET: begin
            reg_we <= 1'b1;
            reg_waddr <= reg_addr;
            reg_wdata <= reg_rdata | (8'h01 << bit_sel); // [RQ18]
          end
          `OP_BCLR: begin
            reg_we <= 1'b1;
            reg_waddr <= reg_addr;
            reg_wdata <= reg_rdata & ~(8'h01 << bit_sel); // [RQ18]
          end
          `OP_BTEST: begin
            bit_test <= reg_rdata[bit_sel]; // [RQ18]
          end
          `OP_NVD_RD: begin
            work_register <= nvm_data_reg;
          end
          default: begin
            work_register <= work_register;
          end
        endcase
      end
    end
  end

  // Program flow: jumps, calls, returns and interrupt enable
  always @(posedge mclk) begin
    if (!resetn) begin
      pc_load <= 1'b0;
      pc_target <= {PC_W{1'b0}};
      stack_push <= 1'b0;
      push_addr <= {PC_W{1'b0}};
      stack_pop <= 1'b0;
      int_enable <= 1'b0;
    end else begin
      pc_load <= 1'b0;
      stack_push <= 1'b0;
      stack_pop <= 1'b0;
      if (take) begin
        case (opcode)
          `OP_IRET: begin
            stack_pop <= 1'b1; // [RQ10]
            pc_load <= 1'b1;
            pc_target <= pop_addr;
            int_enable <= 1'b1; // [RQ10]
          end
          `OP_ICALL: begin
            stack_push <= 1'b1; // [RQ11]
            push_addr <= pc_next;
            pc_load <= 1'b1;
            pc_target <= wreg_target; // [RQ11]
          end
          `OP_IJMP: begin
            pc_load <= 1'b1;
            pc_target <= wreg_target; // [RQ12]
          end
          `OP_LONG_CALL: begin
            stack_push <= 1'b1; // [RQ13]
            push_addr <= pc_next;
            pc_load <= 1'b1;
            pc_target <= addr_field; // [RQ13]
          end
          `OP_LJMP: begin
            pc_load <= 1'b1;
            pc_target <= addr_field; // [RQ13]
          end
          default: begin
            pc_target <= pc_target;
          end
        endcase
      end
    end
  end

  // Watchdog restart pulse
  always @(posedge mclk) begin
    if (!resetn) begin
      wdt_restart <= 1'b0;
    end else begin
      wdt_restart <= kick; // [RQ7]
    end
  end

  // Nonvolatile address/data registers, read, unlock and gated write
  always @(posedge mclk) begin
    if (!resetn) begin
      nvm_addr_reg <= 8'h00;
      nvm_data_reg <= 8'h00;
      nvm_rd_req <= 1'b0;
      nvm_wr_req <= 1'b0;
      nvm_unlocked <= 1'b0;
      nvm_wr_refused <= 1'b0;
    end else begin
      nvm_rd_req <= 1'b0;
      nvm_wr_req <= 1'b0;
      nvm_wr_refused <= 1'b0;
      if (nvm_rd_valid) begin
        nvm_data_reg <= nvm_rdata; // [RQ14]
      end
      if (take) begin
        case (opcode)
          `OP_NVA_LD: begin
            nvm_addr_reg <= work_register;
          end
          `OP_NVD_LD: begin
            nvm_data_reg <= work_register;
          end
          `OP_NV_RD: begin
            nvm_rd_req <= 1'b1; // [RQ14]
          end
          `OP_UNLOCK: begin
            nvm_unlocked <= (imm == NVM_KEY); // [RQ16]
          end
          `OP_NV_WR: begin
            nvm_wr_req <= nvm_unlocked; // [RQ15] [RQ16]
            nvm_wr_refused <= ~nvm_unlocked; // [RQ16]
            nvm_unlocked <= 1'b0;
          end
          default: begin
            nvm_unlocked <= nvm_unlocked;
          end
        endcase
      end
    end
  end
endmodule // mcu_arith_and_control_ops

//--- tb/alu_ops_assertions.sv
// Concurrent checks on the ports of the arithmetic and control operation block
`timescale 1ns/1ps
`include "alu_ops_consts.vh"
module alu_ops_checker #(
  parameter PC_W = 11
) (
  input wire mclk,
  input wire resetn,
  input wire instr_valid,
  input wire [`OP_W-1:0] opcode,
  input wire [`RADDR_W-1:0] reg_addr,
  input wire dest_sel,
  input wire [PC_W-1:0] addr_field,
  input wire [PC_W-1:0] pc_next,
  input wire [PC_W-9:0] pc_high_buf,
  input wire wdt_timeout,
  input wire [7:0] work_register,
  input wire zero_flag,
  input wire digit_carry,
  input wire watchdog_expired_n,
  input wire powerdown_flag_n,
  input wire halt_mode,
  input wire wdt_restart,
  input wire reg_we,
  input wire [`RADDR_W-1:0] reg_waddr,
  input wire pc_load,
  input wire [PC_W-1:0] pc_target,
  input wire stack_push,
  input wire [PC_W-1:0] push_addr,
  input wire stack_pop,
  input wire int_enable,
  input wire busy,
  input wire nvm_unlocked,
  input wire nvm_wr_req,
  input wire nvm_wr_refused
);
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (!resetn);
  // Instruction accepted at this edge
  wire take = instr_valid && !busy && !halt_mode;
  wire flow = opcode >= `OP_IRET && opcode <= `OP_LJMP;
  a_reset_flags: assert property ($rose(resetn) |-> watchdog_expired_n && powerdown_flag_n)
    else $error("status flags wrong after reset");
  a_halt_flags: assert property (take && opcode == `OP_HALT |=> halt_mode && !powerdown_flag_n
    && watchdog_expired_n) else $error("halt entry flags wrong");
  a_timeout_clears: assert property (wdt_timeout |=> !watchdog_expired_n)
    else $error("timeout flag not cleared");
  a_kick_sets: assert property (take && opcode == `OP_KICK && !wdt_timeout |=> wdt_restart
    && watchdog_expired_n && powerdown_flag_n) else $error("kick flags wrong");
  a_flow_two_cyc: assert property (take && flow |=> busy && pc_load ##1 !busy)
    else $error("flow op not two cycles");
  a_long_target: assert property (take && opcode == `OP_LJMP |=> pc_target == $past(addr_field))
    else $error("long jump target wrong");
  a_call_push: assert property (take && (opcode == `OP_LONG_CALL || opcode == `OP_ICALL) |=>
    stack_push && push_addr == $past(pc_next)) else $error("call push wrong");
  a_indirect_tgt: assert property (take && (opcode == `OP_IJMP || opcode == `OP_ICALL) |=>
    pc_target == {$past(pc_high_buf), $past(work_register)})
    else $error("indirect target wrong");
  a_iret_pop: assert property (take && opcode == `OP_IRET |=> stack_pop && int_enable)
    else $error("interrupt return wrong");
  a_write_gate: assert property (take && opcode == `OP_NV_WR |=> nvm_wr_req == $past(nvm_unlocked)
    && nvm_wr_refused != $past(nvm_unlocked)) else $error("write gating wrong");
  a_dest_write: assert property (take && opcode <= `OP_SBC_R && dest_sel |=> reg_we
    && reg_waddr == $past(reg_addr)) else $error("write back wrong");
  a_bcd_flags: assert property (take && opcode == `OP_BCD |=> $stable(zero_flag)
    && $stable(digit_carry)) else $error("decimal adjust moved Z or DC");
  c_halt: cover property (take && opcode == `OP_HALT);
  c_flow: cover property (take && flow);
  c_nv_write: cover property (nvm_wr_req);
endmodule // alu_ops_checker
bind mcu_arith_and_control_ops alu_ops_checker #(.PC_W(PC_W)) chk_u (.mclk, .resetn,
  .instr_valid, .opcode, .reg_addr, .dest_sel, .addr_field, .pc_next, .pc_high_buf,
  .wdt_timeout, .work_register, .zero_flag, .digit_carry, .watchdog_expired_n,
  .powerdown_flag_n, .halt_mode, .wdt_restart, .reg_we, .reg_waddr, .pc_load, .pc_target,
  .stack_push, .push_addr, .stack_pop, .int_enable, .busy, .nvm_unlocked, .nvm_wr_req,
  .nvm_wr_refused);

//--- tb/mcu_arith_and_control_ops_tb_top.sv
// Self-checking bench for the arithmetic and control operation block
`timescale 1ns/1ps
`include "alu_ops_consts.vh"
module mcu_arith_and_control_ops_tb_top;
  logic mclk = 0, resetn = 0, instr_valid = 0, dest_sel = 0, wdt_timeout = 0, wake = 0;
  logic nvm_rd_valid = 0;
  logic [4:0] opcode = 0;
  logic [5:0] reg_addr = 0;
  logic [2:0] bit_sel = 0, pc_high_buf = 3'h5;
  logic [7:0] imm = 0, reg_rdata = 0, nvm_rdata = 0, work_register, nvm_addr_reg, nvm_data_reg;
  logic [10:0] addr_field = 11'h7A5, pc_next = 11'h123, pop_addr = 11'h456, pc_target;
  logic [10:0] push_addr;
  logic zero_flag, digit_carry, carry_flag, watchdog_expired_n, powerdown_flag_n, halt_mode;
  logic wdt_restart, reg_we, bit_test, pc_load, stack_push, stack_pop, int_enable, busy;
  logic nvm_rd_req, nvm_wr_req, nvm_unlocked, nvm_wr_refused;
  logic [5:0] reg_waddr;
  logic [7:0] reg_wdata, ew;
  logic ec;
  logic [10:0] tgt;
  logic [4:0] fl [5] = '{`OP_IRET, `OP_ICALL, `OP_IJMP, `OP_LONG_CALL, `OP_LJMP};
  int fail_count = 0, cmp_count = 0;

  mcu_arith_and_control_ops dut_u (.mclk, .resetn, .instr_valid, .opcode, .reg_addr,
    .dest_sel, .bit_sel, .imm, .addr_field, .reg_rdata, .pc_next, .pc_high_buf, .pop_addr,
    .wdt_timeout, .wake, .nvm_rd_valid, .nvm_rdata, .work_register, .zero_flag, .digit_carry,
    .carry_flag, .watchdog_expired_n, .powerdown_flag_n, .halt_mode, .wdt_restart, .reg_we,
    .reg_waddr, .reg_wdata, .bit_test, .pc_load, .pc_target, .stack_push, .push_addr,
    .stack_pop, .int_enable, .busy, .nvm_addr_reg, .nvm_data_reg, .nvm_rd_req, .nvm_wr_req,
    .nvm_unlocked, .nvm_wr_refused);

  // Clock at 40 MHz
  always #12.5 mclk = ~mclk;

  task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task complete_run;
    $display("Comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  // Offer one instruction, sample results after the taking edge
  // Valid stays high until the next offer or strobe replaces or drops it
  task automatic issue(input logic [4:0] op, input logic d, input logic [7:0] im);
    opcode = op;
    dest_sel = d;
    imm = im;
    instr_valid = 1;
    @(posedge mclk);
    #2;
  endtask

  // One pulse on a side input
  task automatic strobe(ref logic s);
    instr_valid = 0;
    s = 1;
    @(posedge mclk);
    #2;
    s = 0;
  endtask

  // Arithmetic op against a reference sum; opcode bit 1 subtracts, bit 0 adds carry
  task automatic run_op(input logic [4:0] op, input logic d, input logic [7:0] v);
    logic [7:0] b, s;
    logic cin, co, dc;
    b = op[1] ? ~ew : ew;
    cin = op[0] & ec;
    {co, s} = v + b + cin;
    dc = ({1'b0, v[3:0]} + b[3:0] + cin) > 5'hF;
    reg_rdata = v;
    reg_addr = 6'h3F - v[5:0];
    issue(op, d, v);
    check("zero", zero_flag, s == 0);
    check("digit carry", digit_carry, dc);
    check("carry", carry_flag, co);
    if (op[2] || !d) ew = s;
    else begin
      check("write strobe", reg_we, 1);
      check("write data", reg_wdata, s);
      check("write address", reg_waddr, 6'h3F - v[5:0]);
    end
    check("work register", work_register, ew);
    ec = co;
  endtask

  initial begin
    #60000;
    fail_count++;
    complete_run;
  end

  initial begin
    repeat (12) @(posedge mclk);
    #2;
    resetn = 1;
    check("timeout flag", watchdog_expired_n, 1);
    check("power-down flag", powerdown_flag_n, 1);
    // Load the work register through the data register
    nvm_rdata = 8'h12;
    strobe(nvm_rd_valid);
    issue(`OP_NVD_RD, 0, 0);
    ew = 8'h12;
    check("loaded work register", work_register, ew);
    for (int k = 0; k < 16; k++) run_op(k[2:0], k[3], 8'(8'hE7 + k * 8'h2D));
    run_op(`OP_ADD_I, 0, 8'h00 - ew);
    run_op(`OP_ADD_I, 0, 8'h48 - ew);
    run_op(`OP_ADD_I, 0, 8'h39);
    issue(`OP_BCD, 0, 0);
    check("bcd low", work_register, 8'h87);
    check("bcd carry low", carry_flag, 0);
    ew = 8'h87;
    run_op(`OP_ADD_I, 0, 8'h25);
    issue(`OP_BCD, 0, 0);
    check("bcd high", work_register, 8'h12);
    check("bcd carry high", carry_flag, 1);
    ew = 8'h12;
    // Flow ops, each followed by a refused offer in the dead cycle
    foreach (fl[i]) begin
      tgt = fl[i] == `OP_IRET ? pop_addr : fl[i] <= `OP_IJMP ? {3'h5, ew} : addr_field;
      issue(fl[i], 0, 0);
      check("pc load", pc_load, 1);
      check("target", pc_target, tgt);
      check("push", stack_push, fl[i] == `OP_ICALL || fl[i] == `OP_LONG_CALL);
      if (stack_push) check("push address", push_addr, 11'h123);
      check("busy", busy, 1);
      if (fl[i] == `OP_IRET) check("pop and enable", {stack_pop, int_enable}, 2'b11);
      issue(`OP_ADD_I, 0, 8'h01);
      check("busy refusal", work_register, ew);
      check("busy done", busy, 0);
    end
    issue(`OP_HALT, 0, 0);
    check("halt flags", {halt_mode, powerdown_flag_n, watchdog_expired_n}, 3'b101);
    issue(`OP_ADD_I, 0, 8'h01);
    check("halt refusal", work_register, ew);
    strobe(wake);
    check("wake", halt_mode, 0);
    strobe(wdt_timeout);
    check("timeout", watchdog_expired_n, 0);
    issue(`OP_KICK, 0, 0);
    check("kick", {wdt_restart, watchdog_expired_n, powerdown_flag_n}, 3'b111);
    // Nonvolatile access and unlock gating
    issue(`OP_NVA_LD, 0, 0);
    check("address register", nvm_addr_reg, ew);
    issue(`OP_NV_WR, 0, 0);
    check("locked write", {nvm_wr_req, nvm_wr_refused}, 2'b01);
    issue(`OP_UNLOCK, 0, ~`NVM_KEY_RST);
    check("wrong key", nvm_unlocked, 0);
    issue(`OP_UNLOCK, 0, `NVM_KEY_RST);
    check("right key", nvm_unlocked, 1);
    issue(`OP_NV_WR, 0, 0);
    check("write", {nvm_wr_req, nvm_wr_refused, nvm_unlocked}, 3'b100);
    issue(`OP_NV_RD, 0, 0);
    check("read request", nvm_rd_req, 1);
    issue(`OP_NVD_LD, 0, 0);
    check("data register", nvm_data_reg, ew);
    issue(`OP_UNLOCK, 0, `NVM_KEY_RST);
    issue(`OP_UNLOCK, 0, ~`NVM_KEY_RST);
    check("key cleared", nvm_unlocked, 0);
    // Bit set, clear and test on one register value
    reg_rdata = 8'h5A;
    reg_addr = 6'h15;
    bit_sel = 3'h2;
    issue(`OP_BSET, 0, 0);
    check("bit set", {reg_we, reg_waddr, reg_wdata}, {1'b1, 6'h15, 8'h5E});
    bit_sel = 3'h3;
    issue(`OP_BCLR, 0, 0);
    check("bit clear", {reg_we, reg_waddr, reg_wdata}, {1'b1, 6'h15, 8'h52});
    bit_sel = 3'h4;
    issue(`OP_BTEST, 0, 0);
    check("bit test set", bit_test, 1);
    bit_sel = 3'h5;
    issue(`OP_BTEST, 0, 0);
    check("bit test clear", bit_test, 0);
    complete_run;
  end
endmodule // mcu_arith_and_control_ops_tb_top
